// ### src/nvm_ctrl.sv
// Overview of operation
// - timing select picks 3.2/2.2 ms or 3.7/3.0 ms erase/write durations.
// - wipe enable needed before erase; hardware clears it when erase ends.
// - with wipe enable stored low no erase starts; an erase already running still reaches the array.
// - writing wipe go starts erase; reads one until hardware clears it.
// - wipe go is ignored unless wipe enable was already set.
// - mode bit zero picks byte operations, one picks page operations.
// - a 16-byte page buffer serves page mode.
// - program enable needed before writes; low enable blocks new writes, not one already running.
// - hardware clears program enable when a write completes.
// - writing program go starts a write; stays one until it ends.
// - program go is ignored unless program enable was set before.
// - fetch enable needed before reads; low enable blocks new reads, not one already running.
// - writing fetch go starts a read; reads one until hardware clears it.
// - fetch go is ignored unless fetch enable was set before.
// - byte read: mode zero, address, enable, go; data appears at end.
// - fetched byte stays in the data register until a data write or the next fetch.
// - array holds 512 bytes addressed by low byte plus one high bit.
// - high address bit 0 is address bit 8; other bits read zero.
`timescale 1ns/100ps
`default_nettype none
`include "nvm_regs.svh"

module nvm_ctrl #(
    // slow subsidiary clock rate, sets the erase and write tick counts
    parameter int SLOW_HZ = 32000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // special function register port
    input wire nvm_pkg::nvm_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    // slow subsidiary clock, sampled
    input wire logic slow_clock,
    // operation in progress
    output logic nvm_busy
);

    // tick counts, rounded up, never below one
    localparam longint NS_PER_S = 64'd1000000000;
    localparam int WIPE_TICKS0 = int'((longint'(`NVM_WIPE_T0_NS) * SLOW_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam int WIPE_TICKS1 = int'((longint'(`NVM_WIPE_T1_NS) * SLOW_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam int PROG_TICKS0 = int'((longint'(`NVM_PROGRAM_T0_NS) * SLOW_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam int PROG_TICKS1 = int'((longint'(`NVM_PROGRAM_T1_NS) * SLOW_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam logic [1:0] FETCH_LAST = 2'(`NVM_READ_CYCLES - 1);

    nvm_pkg::nvm_core_t s;
    nvm_pkg::nvm_core_t next_s;
    nvm_pkg::nvm_control_t wr_ctl;
    logic timer_done;
    logic [8:0] cur_addr;
    logic [7:0] mem_q;
    logic ctl_write;
    logic data_write;
    logic commit_prog;
    logic commit_wipe;
    logic [7:0] page_slot [`NVM_PAGE_BYTES];

    logic [7:0] mem [`NVM_ARRAY_BYTES];

    // decode of the current access
    assign wr_ctl = nvm_pkg::nvm_control_t'(sfr_req.wdata);
    assign ctl_write = sfr_req.wr && (sfr_req.addr == `NVM_CONTROL_IDX);
    assign data_write = sfr_req.wr && (sfr_req.addr == `NVM_DATA_IDX);
    assign cur_addr = {s.addr_bit_nine, s.addr_low};
    assign mem_q = mem[cur_addr];

    // array updates land on timer completion only
    assign commit_prog = timer_done && (s.phase == nvm_pkg::st_prog);
    assign commit_wipe = timer_done && (s.phase == nvm_pkg::st_wipe);

    // outputs straight from state
    assign sfr_rdata = s.rdata;
    assign nvm_busy = s.busy;

    // slow clock timer for erase and write cycles
    nvm_timer #(
        .WIPE_TICKS0(WIPE_TICKS0),
        .WIPE_TICKS1(WIPE_TICKS1),
        .PROG_TICKS0(PROG_TICKS0),
        .PROG_TICKS1(PROG_TICKS1)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .slow_clock(slow_clock),
        .start(s.timer_start),
        .is_wipe(s.phase == nvm_pkg::st_wipe),
        .timing_sel(s.ctl.timing_sel),
        .done(timer_done)
    );

    // next state: register writes, then phase progress
    always_comb begin
        next_s = s;
        next_s.timer_start = 1'b0;
        if (sfr_req.wr) begin
            case (sfr_req.addr)
                `NVM_ADDR_LOW_IDX: begin
                    next_s.addr_low = sfr_req.wdata;
                end
                `NVM_ADDR_HIGH_IDX: begin
                    next_s.addr_bit_nine = sfr_req.wdata[0];
                end
                `NVM_DATA_IDX: begin
                    next_s.data = sfr_req.wdata;
                    // page mode data lands in buffer
                    if (s.ctl.page_mode) begin
                        next_s.page_buf[s.addr_low[3:0]] = sfr_req.wdata;
                    end
                end
                `NVM_CONTROL_IDX: begin
                    // plain bits follow the write directly
                    next_s.ctl.timing_sel = wr_ctl.timing_sel;
                    next_s.ctl.wipe_enable = wr_ctl.wipe_enable;
                    next_s.ctl.page_mode = wr_ctl.page_mode;
                    next_s.ctl.program_enable = wr_ctl.program_enable;
                    next_s.ctl.fetch_enable = wr_ctl.fetch_enable;
                    // triggers honoured only when idle and enable already stored
                    if (s.phase == nvm_pkg::st_idle) begin
                        if (wr_ctl.wipe_go && s.ctl.wipe_enable) begin
                            next_s.ctl.wipe_go = 1'b1;
                            next_s.phase = nvm_pkg::st_wipe;
                            next_s.timer_start = 1'b1;
                        end else if (wr_ctl.program_go && s.ctl.program_enable) begin
                            next_s.ctl.program_go = 1'b1;
                            next_s.phase = nvm_pkg::st_prog;
                            next_s.timer_start = 1'b1;
                        end else if (wr_ctl.fetch_go && s.ctl.fetch_enable) begin
                            next_s.ctl.fetch_go = 1'b1;
                            next_s.phase = nvm_pkg::st_fetch;
                            next_s.fetch_cnt = 2'h0;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // phase progress
        case (s.phase)
            nvm_pkg::st_idle: begin
            end
            nvm_pkg::st_fetch: begin
                if (s.fetch_cnt == FETCH_LAST) begin
                    next_s.data = mem_q;
                    next_s.ctl.fetch_go = 1'b0;
                    next_s.phase = nvm_pkg::st_idle;
                end else begin
                    next_s.fetch_cnt = s.fetch_cnt + 2'h1;
                end
            end
            nvm_pkg::st_prog: begin
                if (timer_done) begin
                    // enable and go cleared at end
                    next_s.ctl.program_go = 1'b0;
                    next_s.ctl.program_enable = 1'b0;
                    next_s.phase = nvm_pkg::st_idle;
                end
            end
            nvm_pkg::st_wipe: begin
                if (timer_done) begin
                    // enable and go cleared at end
                    next_s.ctl.wipe_go = 1'b0;
                    next_s.ctl.wipe_enable = 1'b0;
                    next_s.phase = nvm_pkg::st_idle;
                end
            end
            default: begin
                next_s.phase = nvm_pkg::st_idle;
            end
        endcase
        // page buffer empties when the program or wipe enable falls
        if ((s.ctl.program_enable && !next_s.ctl.program_enable) ||
            (s.ctl.wipe_enable && !next_s.ctl.wipe_enable)) begin
            next_s.page_buf = '0;
        end
        next_s.busy = (next_s.phase != nvm_pkg::st_idle);
        // registered read answer
        if (sfr_req.rd) begin
            case (sfr_req.addr)
                `NVM_ADDR_LOW_IDX: next_s.rdata = s.addr_low;
                `NVM_ADDR_HIGH_IDX: next_s.rdata = {7'h00, s.addr_bit_nine};
                `NVM_DATA_IDX: next_s.rdata = s.data;
                `NVM_CONTROL_IDX: next_s.rdata = s.ctl;
                default: next_s.rdata = 8'h00;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.ctl <= `NVM_CONTROL_RST;
            s.data <= `NVM_DATA_RST;
            s.addr_low <= `NVM_ADDR_LOW_RST;
            s.addr_bit_nine <= `NVM_ADDR_HIGH_RST;
        end else begin
            s <= next_s;
        end
    end

    // per-slot page commit data, zero on erase
    for (genvar i = 0; i < `NVM_PAGE_BYTES; i++) begin : g_page
        assign page_slot[i] = commit_wipe ? 8'h00 : s.page_buf[i];
    end

    // byte or page commit by mode, one writer for the array
    always_ff @(posedge clk) begin
        if (!rst && (commit_wipe || commit_prog)) begin
            if (s.ctl.page_mode) begin
                for (int k = 0; k < `NVM_PAGE_BYTES; k++) begin
                    mem[{s.addr_bit_nine, s.addr_low[7:4], 4'(k)}] <= page_slot[k];
                end
            // erase reaches the array only via wipe phase
            end else if (commit_wipe) begin
                mem[cur_addr] <= 8'h00;
            // write reaches the array only via program phase
            end else begin
                mem[cur_addr] <= s.data;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // accepted fetch request and its completion
    sequence fetch_accept_s;
        ctl_write && sfr_req.wdata[`NVM_FETCH_GO_BIT] && !sfr_req.wdata[`NVM_WIPE_GO_BIT] &&
            !sfr_req.wdata[`NVM_PROGRAM_GO_BIT] && s.ctl.fetch_enable && (s.phase == nvm_pkg::st_idle);
    endsequence

    sequence fetch_finish_s;
        s.ctl.fetch_go ##1 s.ctl.fetch_go ##1 (!s.ctl.fetch_go && s.data == $past(mem_q));
    endsequence

    fetch_latency_a: assert property (
        fetch_accept_s |=> fetch_finish_s)
        else $error("fetch did not finish in two cycles");

    fetch_blocked_a: assert property (
        ctl_write && sfr_req.wdata[`NVM_FETCH_GO_BIT] && !s.ctl.fetch_enable && !s.ctl.fetch_go
            |=> !s.ctl.fetch_go && s.phase != nvm_pkg::st_fetch)
        else $error("fetch started without enable");

    wipe_blocked_a: assert property (
        ctl_write && sfr_req.wdata[`NVM_WIPE_GO_BIT] && !s.ctl.wipe_enable && !s.ctl.wipe_go
            |=> !s.ctl.wipe_go && s.phase != nvm_pkg::st_wipe)
        else $error("erase started without enable");

    prog_blocked_a: assert property (
        ctl_write && sfr_req.wdata[`NVM_PROGRAM_GO_BIT] && !s.ctl.program_enable && !s.ctl.program_go
            |=> !s.ctl.program_go && s.phase != nvm_pkg::st_prog)
        else $error("write started without enable");

    wipe_end_a: assert property (
        commit_wipe |=> !s.ctl.wipe_go && !s.ctl.wipe_enable && s.phase == nvm_pkg::st_idle && !s.busy)
        else $error("erase end did not clear flags");

    prog_end_a: assert property (
        commit_prog |=> !s.ctl.program_go && !s.ctl.program_enable && s.phase == nvm_pkg::st_idle)
        else $error("write end did not clear flags");

    prog_hold_a: assert property (
        s.phase == nvm_pkg::st_prog && !timer_done |=> s.ctl.program_go && s.busy)
        else $error("write flag dropped early");

    data_hold_a: assert property (
        !data_write && !(s.phase == nvm_pkg::st_fetch && s.fetch_cnt == FETCH_LAST) |=> $stable(s.data))
        else $error("data register changed without cause");

    high_zero_a: assert property (
        sfr_req.rd && sfr_req.addr == `NVM_ADDR_HIGH_IDX |=> sfr_rdata[7:1] == 7'h00 &&
            sfr_rdata[0] == $past(s.addr_bit_nine))
        else $error("high address read wrong");

    wipe_start_a: assert property (
        s.phase == nvm_pkg::st_idle ##1 s.phase == nvm_pkg::st_wipe |-> s.ctl.wipe_go && s.timer_start)
        else $error("erase entered without flag or timer start");

    // entry into a phase, from idle
    sequence prog_entry_s;
        s.phase == nvm_pkg::st_idle ##1 s.phase == nvm_pkg::st_prog;
    endsequence

    sequence fetch_entry_s;
        s.phase == nvm_pkg::st_idle ##1 s.phase == nvm_pkg::st_fetch;
    endsequence

    prog_start_a: assert property (
        prog_entry_s |-> s.ctl.program_go && s.timer_start && $past(s.ctl.program_enable))
        else $error("write entered without flag, timer or enable");

    fetch_needs_en_a: assert property (
        fetch_entry_s |-> s.ctl.fetch_go && $past(s.ctl.fetch_enable))
        else $error("read entered without stored enable");

    wipe_needs_en_a: assert property (
        s.phase == nvm_pkg::st_idle ##1 s.phase == nvm_pkg::st_wipe |-> $past(s.ctl.wipe_enable))
        else $error("erase entered without stored enable");

    // go flags track their phases exactly
    go_tracks_phase_a: assert property (
        s.ctl.fetch_go == (s.phase == nvm_pkg::st_fetch) && s.ctl.program_go == (s.phase == nvm_pkg::st_prog) &&
            s.ctl.wipe_go == (s.phase == nvm_pkg::st_wipe))
        else $error("go flag and phase disagree");

    busy_level_a: assert property (
        nvm_busy == (s.phase != nvm_pkg::st_idle))
        else $error("busy flag and phase disagree");

    wipe_hold_a: assert property (
        s.phase == nvm_pkg::st_wipe && !timer_done |=> s.ctl.wipe_go && s.busy)
        else $error("erase flag dropped early");

    rdata_hold_a: assert property (
        !sfr_req.rd |=> $stable(sfr_rdata))
        else $error("read answer changed without a read");

    buf_clear_a: assert property (
        $fell(s.ctl.program_enable) || $fell(s.ctl.wipe_enable) |-> s.page_buf == '0)
        else $error("page buffer kept after enable fell");

endmodule : nvm_ctrl

`default_nettype wire

// ### src/nvm_regs.svh
`ifndef NVM_REGS_SVH
`define NVM_REGS_SVH

// register indices on the special function register port
`define NVM_ADDR_LOW_IDX 9'h000
`define NVM_ADDR_HIGH_IDX 9'h001
`define NVM_DATA_IDX 9'h002
`define NVM_CONTROL_IDX 9'h140

// control register bit positions
`define NVM_TIMING_SEL_BIT 7
`define NVM_WIPE_ENABLE_BIT 6
`define NVM_WIPE_GO_BIT 5
`define NVM_MODE_BIT 4
`define NVM_PROGRAM_ENABLE_BIT 3
`define NVM_PROGRAM_GO_BIT 2
`define NVM_FETCH_ENABLE_BIT 1
`define NVM_FETCH_GO_BIT 0

// reset values
`define NVM_CONTROL_RST 8'h00
`define NVM_DATA_RST 8'h00
`define NVM_ADDR_LOW_RST 8'h00
`define NVM_ADDR_HIGH_RST 1'b0

// cycle durations in ns, per timing select value
`define NVM_WIPE_T0_NS 3200000
`define NVM_PROGRAM_T0_NS 2200000
`define NVM_WIPE_T1_NS 3700000
`define NVM_PROGRAM_T1_NS 3000000

// system clock cycles per byte fetch
`define NVM_READ_CYCLES 2
// array and page geometry
`define NVM_ARRAY_BYTES 512
`define NVM_PAGE_BYTES 16

`endif

// ### src/nvm_pkg.sv
package nvm_pkg;

    // controller phases, gray coded along idle-fetch-program-wipe
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_fetch = 2'b01,
        st_prog = 2'b11,
        st_wipe = 2'b10
    } nvm_state_t;

    // control register layout, bit 7 first
    typedef struct packed {
        logic timing_sel;
        logic wipe_enable;
        logic wipe_go;
        logic page_mode;
        logic program_enable;
        logic program_go;
        logic fetch_enable;
        logic fetch_go;
    } nvm_control_t;

    // one access on the special function register port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [8:0] addr;
        logic [7:0] wdata;
    } nvm_sfr_req_t;

    // whole state of the controller
    typedef struct packed {
        nvm_state_t phase;
        nvm_control_t ctl;
        logic [7:0] addr_low;
        logic addr_bit_nine;
        logic [7:0] data;
        logic [1:0] fetch_cnt;
        logic [15:0][7:0] page_buf;
        logic [7:0] rdata;
        logic timer_start;
        logic busy;
    } nvm_core_t;

    // whole state of the slow clock timer
    typedef struct packed {
        logic run;
        logic slow_prev;
        logic [15:0] ticks;
        logic done;
    } nvm_timer_t;

endpackage : nvm_pkg

// ### src/nvm_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "nvm_regs.svh"

module nvm_timer #(
    parameter int WIPE_TICKS0 = 1,
    parameter int WIPE_TICKS1 = 1,
    parameter int PROG_TICKS0 = 1,
    parameter int PROG_TICKS1 = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // slow subsidiary clock, sampled
    input wire logic slow_clock,
    // cycle request
    input wire logic start,
    input wire logic is_wipe,
    input wire logic timing_sel,
    // one-cycle completion pulse
    output logic done
);

    nvm_pkg::nvm_timer_t s;
    nvm_pkg::nvm_timer_t next_s;
    logic slow_rise;

    assign slow_rise = slow_clock & ~s.slow_prev;
    assign done = s.done;

    // tick counter on rising edges of the slow clock
    always_comb begin
        next_s = s;
        next_s.slow_prev = slow_clock;
        next_s.done = 1'b0;
        if (start) begin
            next_s.run = 1'b1;
            if (is_wipe) begin
                next_s.ticks = timing_sel ? 16'(WIPE_TICKS1) : 16'(WIPE_TICKS0);
            end else begin
                next_s.ticks = timing_sel ? 16'(PROG_TICKS1) : 16'(PROG_TICKS0);
            end
        end else if (s.run && slow_rise) begin
            if (s.ticks <= 16'h0001) begin
                next_s.run = 1'b0;
                next_s.done = 1'b1;
            end else begin
                next_s.ticks = s.ticks - 16'h0001;
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wipe_duration_a: assert property (
        start && is_wipe |=> s.ticks == ($past(timing_sel) ? 16'(WIPE_TICKS1) : 16'(WIPE_TICKS0)))
        else $error("wipe duration not loaded");

    done_follows_run_a: assert property (
        s.done |-> $past(s.run) && !s.run)
        else $error("done without a running count");

endmodule : nvm_timer

`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "nvm_regs.svh"

module tb;
    localparam int SLOW_HZ = 1000;
    localparam int SLOW_HALF = 10;
    localparam logic [8:0] CTL = `NVM_CONTROL_IDX;
    localparam logic [8:0] DAT = `NVM_DATA_IDX;
    localparam logic [8:0] ALO = `NVM_ADDR_LOW_IDX;
    localparam logic [8:0] AHI = `NVM_ADDR_HIGH_IDX;

    // design ports
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic slow_clock = 1'b0;
    nvm_pkg::nvm_sfr_req_t sfr_req = '0;
    logic [7:0] sfr_rdata;
    logic nvm_busy;
    int n_mismatch = 0;
    int checks = 0;

    nvm_ctrl #(.SLOW_HZ(SLOW_HZ)) dut (
        .clk(clk),
        .rst(rst),
        .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata),
        .slow_clock(slow_clock),
        .nvm_busy(nvm_busy)
    );

    // system clock
    always #4 clk = ~clk;

    // slow clock runs free and stable from time zero
    always begin
        repeat (SLOW_HALF) @(posedge clk);
        slow_clock <= ~slow_clock;
    end

    // expected slow ticks for a duration in ns
    function automatic int ticks(input longint ns);
        return int'((ns * SLOW_HZ + 64'd999999999) / 64'd1000000000);
    endfunction : ticks

    // byte compare
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // cycle count compare against a window
    task automatic chk_range(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk_range

    // verdict and end of run
    task automatic results();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // one register write, strobe held for one taken edge
    task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_req.wr <= 1'b1;
        sfr_req.addr <= a;
        sfr_req.wdata <= d;
        @(posedge clk);
        sfr_req.wr <= 1'b0;
    endtask : wr_reg

    // one register read, answer one cycle after the taken edge
    task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
        @(posedge clk);
        sfr_req.rd <= 1'b1;
        sfr_req.addr <= a;
        @(posedge clk);
        sfr_req.rd <= 1'b0;
        @(posedge clk);
        #1 chk(sfr_rdata, exp);
    endtask : rd_chk

    // enable, then go in a later write, then wait for the end
    task automatic run_op(input logic [7:0] en, input logic [7:0] go, input logic [7:0] after, output int cyc);
        realtime t0;
        wr_reg(CTL, en);
        wr_reg(CTL, go);
        t0 = $realtime + 1.0;
        #1 chk({7'h00, nvm_busy}, 8'h01);
        if (go[0] == 1'b0) begin
            rd_chk(CTL, go);
        end
        cyc = 0;
        while (nvm_busy === 1'b1 && cyc < 3000) begin
            @(posedge clk);
            #1 cyc++;
        end
        if (cyc >= 3000) begin
            n_mismatch++;
            results();
        end
        cyc = int'(($realtime - t0) / 8.0);
        rd_chk(CTL, after);
    endtask : run_op

    // stimulus
    initial begin
        int cyc;
        int tk;
        logic [8:0] a;
        logic [7:0] d;
        logic [7:0] ts;
        logic [7:0] gos [3];
        gos = '{8'h01, 8'h04, 8'h20};
        void'($urandom(32'hb4c1));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // reset values and an unmapped index
        rd_chk(ALO, `NVM_ADDR_LOW_RST);
        rd_chk(AHI, 8'h00);
        rd_chk(DAT, `NVM_DATA_RST);
        rd_chk(CTL, `NVM_CONTROL_RST);
        wr_reg(9'h003, 8'hFF);
        rd_chk(9'h003, 8'h00);
        wr_reg(AHI, 8'hFF);
        rd_chk(AHI, 8'h01);
        // go bits without a stored enable are refused
        foreach (gos[k]) begin
            wr_reg(CTL, gos[k]);
            #1 chk({7'h00, nvm_busy}, 8'h00);
            rd_chk(CTL, 8'h00);
        end
        // mode bit reads back
        wr_reg(CTL, 8'h10);
        rd_chk(CTL, 8'h10);
        wr_reg(CTL, 8'h00);
        // byte write, read, refused erase, erase, per timing select
        for (int i = 0; i < 6; i++) begin
            ts = {i[0], 7'h00};
            a = (i == 0) ? 9'h1FF : (i == 1) ? 9'h000 : 9'($urandom);
            d = (i == 0) ? 8'hFF : 8'($urandom);
            wr_reg(ALO, a[7:0]);
            wr_reg(AHI, {7'h00, a[8]});
            wr_reg(DAT, d);
            run_op(ts | 8'h08, ts | 8'h0C, ts, cyc);
            tk = ticks(ts[7] ? `NVM_PROGRAM_T1_NS : `NVM_PROGRAM_T0_NS);
            chk_range(cyc, (tk - 1) * 2 * SLOW_HALF + 3, tk * 2 * SLOW_HALF + 2);
            wr_reg(DAT, ~d);
            run_op(ts | 8'h02, ts | 8'h03, ts | 8'h02, cyc);
            chk_range(cyc, `NVM_READ_CYCLES, `NVM_READ_CYCLES);
            rd_chk(DAT, d);
            rd_chk(DAT, d);
            wr_reg(CTL, ts | 8'h20);
            #1 chk({7'h00, nvm_busy}, 8'h00);
            run_op(ts | 8'h02, ts | 8'h03, ts | 8'h02, cyc);
            rd_chk(DAT, d);
            run_op(ts | 8'h40, ts | 8'h60, ts, cyc);
            tk = ticks(ts[7] ? `NVM_WIPE_T1_NS : `NVM_WIPE_T0_NS);
            chk_range(cyc, (tk - 1) * 2 * SLOW_HALF + 3, tk * 2 * SLOW_HALF + 2);
            run_op(ts | 8'h02, ts | 8'h03, ts | 8'h02, cyc);
            rd_chk(DAT, 8'h00);
        end
        // page write of 16 bytes, read back in byte mode
        wr_reg(AHI, 8'h01);
        wr_reg(CTL, 8'h10);
        for (int j = 0; j < `NVM_PAGE_BYTES; j++) begin
            wr_reg(ALO, {4'hA, 4'(j)});
            wr_reg(DAT, 8'(j) ^ 8'h5A);
        end
        run_op(8'h18, 8'h1C, 8'h10, cyc);
        wr_reg(CTL, 8'h00);
        for (int j = 0; j < `NVM_PAGE_BYTES; j++) begin
            wr_reg(ALO, {4'hA, 4'(j)});
            run_op(8'h02, 8'h03, 8'h02, cyc);
            rd_chk(DAT, 8'(j) ^ 8'h5A);
        end
        // page erase clears the page, checked at bytes 0, 5, 10 and 15
        wr_reg(CTL, 8'h10);
        run_op(8'h50, 8'h70, 8'h10, cyc);
        tk = ticks(`NVM_WIPE_T0_NS);
        chk_range(cyc, (tk - 1) * 2 * SLOW_HALF + 3, tk * 2 * SLOW_HALF + 2);
        wr_reg(CTL, 8'h00);
        for (int j = 0; j < `NVM_PAGE_BYTES; j += 5) begin
            wr_reg(ALO, {4'hA, 4'(j)});
            run_op(8'h02, 8'h03, 8'h02, cyc);
            rd_chk(DAT, 8'h00);
        end
        results();
    end
endmodule : tb

`default_nettype wire
